// ### rtl/sacu_pkg.sv
// constants, types and register map of the converter control unit
// assumes one core clock; the analog core and timers live on that clock
//
// Behaviour
// - codes 0-7 pick an input or its pair; codes 1xxx pick the sensor
// - set pair bit: pair is differential, even input plus, odd minus
// - upper four bits of channel select read zero, writes to them ignored
// - nonzero divider N gives SAR clock equal to core clock over 2(N+1)
// - divider zero runs the SAR clock at the core clock rate
// - gain codes 000..011 give 1,2,4,8; 10x gives 16; 11x gives 0.5
// - enable clear holds the converter shut down; set accepts starts
// - track bit clear: enabled converter tracks whenever the sequencer is idle
// - start mode picks busy write, timer 3, external rising edge, timer 2
// - track bit set, modes 00/01/11: three SAR clocks tracking then convert
// - track bit set, mode 10: track while pin low, convert on rising edge
// - busy reads one during three-clock tracking and during a conversion, zero otherwise
// - busy write of one starts only in mode 00; writing zero does nothing
// - done flag sets when busy falls; only software clears it
// - window flag sets on a window match at capture, stays until software clears
// - right justified: result in high[3:0] and low; high[7:4] sign or zero
// - left justified: result in high and low[7:4]; low[3:0] zero
// - single-ended result unsigned 12 bit; differential two's complement
// - conversion lasts 16 SAR clocks after tracking before busy falls
`default_nettype none

package sacu_pkg;

  localparam logic [7:0] ADDR_PAIR_CFG = 8'hB9;
  localparam logic [7:0] ADDR_CHAN_SEL = 8'hBB;
  localparam logic [7:0] ADDR_CLK_GAIN = 8'hBC;
  localparam logic [7:0] ADDR_RES_LOW = 8'hBD;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hBF;
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;

  localparam logic [7:0] RST_PAIR_CFG = 8'h00;
  localparam logic [7:0] RST_CHAN_SEL = 8'h00;
  localparam logic [7:0] RST_CLK_GAIN = 8'hF8;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;

  // control register bit positions
  localparam int CTL_EN = 7;
  localparam int CTL_TM = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_CM_HI = 3;
  localparam int CTL_CM_LO = 2;
  localparam int CTL_WIN = 1;
  localparam int CTL_LJ = 0;
  localparam logic [7:0] CTL_SW_MASK = 8'hEF;

  localparam int CFG_DIV_HI = 7;
  localparam int CFG_DIV_LO = 3;
  localparam int CFG_GAIN_HI = 2;
  localparam int CFG_GAIN_LO = 0;

  localparam logic [1:0] SM_BUSY_WRITE = 2'h0;
  localparam logic [1:0] SM_TIMER3 = 2'h1;
  localparam logic [1:0] SM_EXT_PIN = 2'h2;
  localparam logic [1:0] SM_TIMER2 = 2'h3;

  localparam logic [4:0] TRACK_SAR_CLOCKS = 5'h03;
  localparam logic [4:0] CONV_SAR_CLOCKS = 5'h10;
  localparam logic [3:0] TEMP_SENSOR_SEL = 4'h8;

  // software bound only; the hardware does not clamp the divider
  localparam int CORE_CLK_KHZ = 50000;
  localparam int SAR_MAX_KHZ = 2500;
  localparam int MIN_SAR_DIV = (CORE_CLK_KHZ + 2 * SAR_MAX_KHZ - 1) /
                               (2 * SAR_MAX_KHZ) - 1;

  typedef enum logic [2:0] {
    SACU_GAIN_1 = 3'h0,
    SACU_GAIN_2 = 3'h1,
    SACU_GAIN_4 = 3'h2,
    SACU_GAIN_8 = 3'h3,
    SACU_GAIN_16 = 3'h4,
    SACU_GAIN_HALF = 3'h5
  } sacu_gain_t;

  typedef enum logic [1:0] {
    SACU_IDLE = 2'b00,
    SACU_TRACK = 2'b01,
    SACU_CONV = 2'b11,
    SACU_DONE = 2'b10
  } sacu_state_t;

  typedef struct packed {
    logic powered;
    logic track;
    logic convert;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic diff;
    sacu_gain_t gain;
  } sacu_core_t;

endpackage : sacu_pkg

`default_nettype wire

// ### rtl/sacu_top.sv
// converter control unit: register file, SAR clock divider, start logic,
// sequencing and result formatting for a 12-bit SAR core
// assumes the analog core gives its code on i_core_result by the end of the
// last SAR clock and that timers and window compare run on i_mclk
`default_nettype none

module sacu_top
  import sacu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_timer3_ovf,
  input wire logic i_timer2_ovf,
  input wire logic i_ext_start,
  input wire logic [11:0] i_core_result,
  input wire logic i_window_match,
  output sacu_core_t o_core,
  output logic o_sar_tick,
  output logic o_sar_clk,
  output logic o_busy
);

  logic [3:0] pair_cfg_ff;
  logic [3:0] chan_sel_ff;
  logic [7:0] clk_gain_ff;
  logic [7:0] ctl_ff;
  logic [7:0] res_hi_ff;
  logic [7:0] res_lo_ff;
  logic [7:0] rdata_ff;
  logic [4:0] div_cnt_ff;
  logic sar_phase_ff;
  logic tick_ff;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic ext_prev_ff;
  sacu_state_t state_ff;
  logic [4:0] sar_cnt_ff;
  sacu_core_t core_ff;

  // register decode; reads and writes share one address compare
  wire sel_pair = (i_sfr_addr == ADDR_PAIR_CFG);
  wire sel_chan = (i_sfr_addr == ADDR_CHAN_SEL);
  wire sel_cfg = (i_sfr_addr == ADDR_CLK_GAIN);
  wire sel_ctl = (i_sfr_addr == ADDR_CONTROL);
  wire sel_hi = (i_sfr_addr == ADDR_RES_HIGH);
  wire sel_lo = (i_sfr_addr == ADDR_RES_LOW);

  wire wr_pair = i_sfr_wr && sel_pair;
  wire wr_chan = i_sfr_wr && sel_chan;
  wire wr_cfg = i_sfr_wr && sel_cfg;
  wire wr_ctl = i_sfr_wr && sel_ctl;
  wire wr_hi = i_sfr_wr && sel_hi;
  wire wr_lo = i_sfr_wr && sel_lo;

  wire enabled = ctl_ff[CTL_EN];
  wire track_mode = ctl_ff[CTL_TM];
  wire [1:0] start_mode = ctl_ff[CTL_CM_HI:CTL_CM_LO];
  wire [4:0] sar_div = clk_gain_ff[CFG_DIV_HI:CFG_DIV_LO];
  wire [2:0] gain_field = clk_gain_ff[CFG_GAIN_HI:CFG_GAIN_LO];
  wire busy = (state_ff == SACU_TRACK) || (state_ff == SACU_CONV);

  // SAR clock: half period of sar_div+1 core clocks, tick on rising phase
  // a divider cut below the running count lets the count run on and wrap once
  wire div_wrap = (div_cnt_ff == sar_div);
  wire div_zero = (sar_div == 5'h00);
  wire [4:0] nxt_div_cnt = div_wrap ? 5'h00 : div_cnt_ff + 5'h01;
  wire nxt_sar_phase = div_zero ? 1'b1 :
                       (div_wrap ? ~sar_phase_ff : sar_phase_ff);
  wire nxt_tick = div_zero || (div_wrap && !sar_phase_ff);

  // external pin edge is taken only after the synchroniser pair
  // costs two cycles of pin latency, traded for a clean edge
  wire ext_rise = ext_sync_ff && !ext_prev_ff;

  // trigger selection
  // timer pulses are taken as they come: they share the core clock
  wire busy_wr_start = wr_ctl && i_sfr_wdata[CTL_BUSY] &&
                       (start_mode == SM_BUSY_WRITE);
  logic trigger;
  always_comb begin
    case (start_mode)
      SM_BUSY_WRITE: trigger = busy_wr_start;
      SM_TIMER3: trigger = i_timer3_ovf;
      SM_EXT_PIN: trigger = ext_rise;
      SM_TIMER2: trigger = i_timer2_ovf;
      default: trigger = 1'b0;
    endcase
  end

  // starts are ignored while shut down or mid-conversion
  wire start = enabled && !busy && trigger;
  wire three_clk_track = track_mode && (start_mode != SM_EXT_PIN);
  wire track_done = tick_ff && (sar_cnt_ff == TRACK_SAR_CLOCKS - 5'h01);
  wire conv_done = tick_ff && (sar_cnt_ff == CONV_SAR_CLOCKS - 5'h01);

  // sequencer
  // a trigger landing in DONE is dropped: one dead cycle between runs
  sacu_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SACU_IDLE: begin
        if (start) begin
          nxt_state = three_clk_track ? SACU_TRACK : SACU_CONV;
        end
      end
      SACU_TRACK: begin
        if (track_done) begin
          nxt_state = SACU_CONV;
        end
      end
      SACU_CONV: begin
        if (conv_done) begin
          nxt_state = SACU_DONE;
        end
      end
      SACU_DONE: nxt_state = SACU_IDLE;
      default: nxt_state = SACU_IDLE;
    endcase
    if (!enabled) begin
      nxt_state = SACU_IDLE;
    end
  end

  wire phase_change = (nxt_state != state_ff);
  wire [4:0] nxt_sar_cnt = phase_change ? 5'h00 :
                           (tick_ff ? sar_cnt_ff + 5'h01 : sar_cnt_ff);

  // input selection
  wire [2:0] addr_in = chan_sel_ff[2:0];
  wire pair_diff = pair_cfg_ff[addr_in[2:1]];
  wire temp_sel = chan_sel_ff[3];
  wire sel_diff = !temp_sel && pair_diff;
  wire [3:0] nxt_pos = temp_sel ? TEMP_SENSOR_SEL :
                       (pair_diff ? {1'b0, addr_in[2:1], 1'b0} :
                        {1'b0, addr_in});
  wire [3:0] nxt_neg = sel_diff ? {1'b0, addr_in[2:1], 1'b1} : 4'h0;

  sacu_gain_t gain_dec;
  always_comb begin
    case (gain_field)
      3'h0: gain_dec = SACU_GAIN_1;
      3'h1: gain_dec = SACU_GAIN_2;
      3'h2: gain_dec = SACU_GAIN_4;
      3'h3: gain_dec = SACU_GAIN_8;
      3'h4, 3'h5: gain_dec = SACU_GAIN_16;
      default: gain_dec = SACU_GAIN_HALF;
    endcase
  end

  // tracking: continuous when idle, pin-low window, or the three clocks
  wire idle = (state_ff == SACU_IDLE);
  wire nxt_track = enabled && (
    !track_mode ? idle :
    (start_mode == SM_EXT_PIN) ? (idle && !ext_sync_ff) :
    (state_ff == SACU_TRACK));

  sacu_core_t nxt_core;
  always_comb begin
    nxt_core.powered = enabled;
    nxt_core.track = nxt_track;
    nxt_core.convert = enabled && (state_ff == SACU_CONV);
    nxt_core.pos_sel = nxt_pos;
    nxt_core.neg_sel = nxt_neg;
    nxt_core.diff = sel_diff;
    nxt_core.gain = gain_dec;
  end

  // result formatting; the core code is two's complement when differential
  // window level counts only at capture; a match between runs is not seen
  wire capture = (state_ff == SACU_CONV) && conv_done;
  wire res_sign = sel_diff && i_core_result[11];
  wire [7:0] fmt_hi = ctl_ff[CTL_LJ] ? i_core_result[11:4] :
                      {{4{res_sign}}, i_core_result[11:8]};
  wire [7:0] fmt_lo = ctl_ff[CTL_LJ] ? {i_core_result[3:0], 4'h0} :
                      i_core_result[7:0];
  wire [7:0] nxt_res_hi = capture ? fmt_hi :
                          (wr_hi ? i_sfr_wdata : res_hi_ff);
  wire [7:0] nxt_res_lo = capture ? fmt_lo :
                          (wr_lo ? i_sfr_wdata : res_lo_ff);

  // control register: software bits, then flags where a set beats a clear
  wire [7:0] ctl_sw = wr_ctl ? (i_sfr_wdata & CTL_SW_MASK) :
                      (ctl_ff & CTL_SW_MASK);
  wire set_done = capture;
  wire set_win = capture && i_window_match;
  logic [7:0] nxt_ctl;
  always_comb begin
    nxt_ctl = ctl_sw;
    nxt_ctl[CTL_DONE] = set_done || ctl_sw[CTL_DONE];
    nxt_ctl[CTL_WIN] = set_win || ctl_sw[CTL_WIN];
    nxt_ctl[CTL_BUSY] = (nxt_state == SACU_TRACK) ||
                        (nxt_state == SACU_CONV);
  end

  // read mux; unmapped addresses read zero
  wire [7:0] nxt_rdata =
    sel_pair ? {4'h0, pair_cfg_ff} :
    sel_chan ? {4'h0, chan_sel_ff} :
    sel_cfg ? clk_gain_ff :
    sel_ctl ? ctl_ff :
    sel_hi ? res_hi_ff :
    sel_lo ? res_lo_ff : 8'h00;

  wire [3:0] nxt_pair = wr_pair ? i_sfr_wdata[3:0] : pair_cfg_ff;
  wire [3:0] nxt_chan = wr_chan ? i_sfr_wdata[3:0] : chan_sel_ff;
  wire [7:0] nxt_cfg = wr_cfg ? i_sfr_wdata : clk_gain_ff;

  // software-visible configuration
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pair_cfg_ff <= RST_PAIR_CFG[3:0];
      chan_sel_ff <= RST_CHAN_SEL[3:0];
      clk_gain_ff <= RST_CLK_GAIN;
    end else begin
      pair_cfg_ff <= nxt_pair;
      chan_sel_ff <= nxt_chan;
      clk_gain_ff <= nxt_cfg;
    end
  end

  // control and flags; busy is folded in from the next sequencer state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctl_ff <= RST_CONTROL;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // results are writable, but a capture in the same cycle wins
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      res_hi_ff <= RST_RESULT;
      res_lo_ff <= RST_RESULT;
    end else begin
      res_hi_ff <= nxt_res_hi;
      res_lo_ff <= nxt_res_lo;
    end
  end

  // SAR clock divider
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_cnt_ff <= 5'h00;
      sar_phase_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      sar_phase_ff <= nxt_sar_phase;
      tick_ff <= nxt_tick;
    end
  end

  // pin synchroniser; only the second stage feeds logic
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      ext_meta_ff <= i_ext_start;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  // sequencer state and SAR clock count
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_ff <= SACU_IDLE;
      sar_cnt_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      sar_cnt_ff <= nxt_sar_cnt;
    end
  end

  // registered outputs toward the core and the register bus
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      core_ff <= '0;
      rdata_ff <= 8'h00;
    end else begin
      core_ff <= nxt_core;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_sfr_rdata = rdata_ff;
  assign o_core = core_ff;
  assign o_sar_tick = tick_ff;
  assign o_sar_clk = sar_phase_ff;
  assign o_busy = ctl_ff[CTL_BUSY];

endmodule : sacu_top

`default_nettype wire

// ### tb/sacu_far.sv
// far-side model: analog core code, window comparator and timer overflows
// assumes the code and window level matter only while converting
`default_nettype none

module sacu_far
  import sacu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire sacu_core_t i_core,
  input wire logic [11:0] i_code,
  input wire logic i_win,
  input wire logic [1:0] i_fire,
  output logic [11:0] o_result,
  output logic o_window_match,
  output logic o_timer3_ovf,
  output logic o_timer2_ovf
);
  logic [11:0] junk_ff;

  // outside a conversion the lines churn, so a stale capture shows up
  always_ff @(posedge i_mclk) begin
    junk_ff <= i_rst_n ? junk_ff + 12'h3B7 : 12'hA5C;
  end

  assign o_result = i_core.convert ? i_code : junk_ff;
  assign o_window_match = i_core.convert ? i_win : junk_ff[0];
  assign o_timer3_ovf = i_fire[0];
  assign o_timer2_ovf = i_fire[1];
endmodule : sacu_far

`default_nettype wire

// ### tb/sacu_top_monitor.sv
// port checker for the converter control unit, bound onto sacu_top
// assumes one clock domain and the synchronous active-low reset
`default_nettype none

module sacu_top_monitor
  import sacu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_timer3_ovf,
  input wire logic i_timer2_ovf,
  input wire logic i_ext_start,
  input wire logic [11:0] i_core_result,
  input wire logic i_window_match,
  input wire sacu_core_t o_core,
  input wire logic o_sar_tick,
  input wire logic o_sar_clk,
  input wire logic o_busy
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // shadow of the stored control bits, rebuilt from the writes seen
  logic [7:0] ctl_seen_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctl_seen_ff <= RST_CONTROL;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_CONTROL) begin
      ctl_seen_ff <= i_sfr_wdata;
    end
  end
  wire shadow_on = ctl_seen_ff[CTL_EN];
  wire [1:0] shadow_mode = ctl_seen_ff[CTL_CM_HI:CTL_CM_LO];

  property p_chan_hi;
    i_sfr_addr == ADDR_CHAN_SEL |=> o_sfr_rdata[7:4] == 4'h0;
  endproperty
  a_chan_hi: assert property (p_chan_hi)
    else $error("channel select upper bits read nonzero");
  // enable and mode in force are the stored ones, not those being written
  property p_start;
    i_sfr_wr && i_sfr_addr == ADDR_CONTROL && i_sfr_wdata[CTL_BUSY] &&
    shadow_on && shadow_mode == SM_BUSY_WRITE && !o_busy &&
    !$past(o_busy) |=> o_busy;
  endproperty
  a_start: assert property (p_start)
    else $error("busy write did not start a conversion");
  property p_power;
    !o_core.powered |-> !o_core.track && !o_core.convert;
  endproperty
  a_power: assert property (p_power)
    else $error("core active while shut down");
  property p_conv;
    o_core.convert |-> $past(o_busy);
  endproperty
  a_conv: assert property (p_conv)
    else $error("converting without busy");
  property p_excl;
    o_core.track |-> !o_core.convert;
  endproperty
  a_excl: assert property (p_excl)
    else $error("tracking and converting together");
  property p_diff;
    o_core.diff |-> !o_core.pos_sel[0] && !o_core.pos_sel[3] &&
      o_core.neg_sel == o_core.pos_sel + 4'h1;
  endproperty
  a_diff: assert property (p_diff)
    else $error("differential pair selection wrong");
  property p_temp;
    o_core.pos_sel[3] |-> o_core.pos_sel == TEMP_SENSOR_SEL && !o_core.diff;
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature sensor selection wrong");
  property p_busy_len;
    $rose(o_busy) |-> (o_busy || !shadow_on)[*8] ##1
      (o_busy || !shadow_on)[*8];
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("conversion shorter than sixteen cycles");
  property p_fall;
    $fell(o_busy) && shadow_on |-> $past(o_sar_tick);
  endproperty
  a_fall: assert property (p_fall)
    else $error("busy fell without a SAR tick");

  c_conv: cover property ($rose(o_busy));
  c_diff: cover property (o_core.diff && o_core.convert);
  c_temp: cover property (o_core.pos_sel == TEMP_SENSOR_SEL && o_core.convert);
endmodule : sacu_top_monitor

bind sacu_top sacu_top_monitor u_mon (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
  .o_sfr_rdata(o_sfr_rdata), .i_timer3_ovf(i_timer3_ovf),
  .i_timer2_ovf(i_timer2_ovf), .i_ext_start(i_ext_start),
  .i_core_result(i_core_result), .i_window_match(i_window_match),
  .o_core(o_core), .o_sar_tick(o_sar_tick), .o_sar_clk(o_sar_clk),
  .o_busy(o_busy));

`default_nettype wire

// ### tb/sacu_top_bench.sv
// bench for the converter control unit: registers, starts and results
// assumes sacu_top with the far-side model sacu_far beside it
`default_nettype none

module sacu_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sacu_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, pin = 1'b0, win = 1'b0;
  logic [1:0] fire = 2'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [11:0] code = 12'h000, res;
  logic t3, t2, wm, tick, sclk, busy;
  sacu_core_t core;
  int failures = 0, checked = 0, cycles = 0, blen = 0, since = 0, gap = 0;

  sacu_top DUT (.i_mclk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_timer3_ovf(t3), .i_timer2_ovf(t2), .i_ext_start(pin),
    .i_core_result(res), .i_window_match(wm), .o_core(core),
    .o_sar_tick(tick), .o_sar_clk(sclk), .o_busy(busy));
  sacu_far u_far (.i_mclk(clk), .i_rst_n(rst_n), .i_core(core),
    .i_code(code), .i_win(win), .i_fire(fire), .o_result(res),
    .o_window_match(wm), .o_timer3_ovf(t3), .o_timer2_ovf(t2));

  always #10 clk = ~clk;
  // busy length and tick spacing are measured here, away from the stimulus
  always @(posedge clk) begin
    cycles <= cycles + 1;
    blen <= blen + int'(busy === 1'b1);
    gap <= tick === 1'b1 ? since : gap;
    since <= tick === 1'b1 ? 1 : since + 1;
    if (cycles == 60000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask : put

  task automatic get(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    step(1);
    d = rdata;
  endtask : get

  function automatic logic [15:0] fmt(input logic [11:0] r, input logic lj,
                                      input logic d);
    return lj ? {r, 4'h0} : {{4{d & r[11]}}, r};
  endfunction : fmt

  initial begin
    static logic [7:0] ra [7] = '{ADDR_PAIR_CFG, ADDR_CHAN_SEL, ADDR_CLK_GAIN,
      ADDR_RES_LOW, ADDR_RES_HIGH, ADDR_CONTROL, 8'h01};
    static logic [7:0] re [7] = '{RST_PAIR_CFG, RST_CHAN_SEL, RST_CLK_GAIN,
      RST_RESULT, RST_RESULT, RST_CONTROL, 8'h00};
    logic [7:0] v, u, c;
    logic [4:0] dv;
    logic [3:0] ch, pr;
    logic [1:0] md;
    logic tm, lj, df;
    int p, lim, b0;
    p = $urandom(61577);
    step(4);
    rst_n = 1'b1;
    put(8'h01, 8'h5A);
    foreach (ra[i]) begin
      get(ra[i], v);
      chk(v, re[i]);
    end
    put(ADDR_CONTROL, 8'h10);
    chk(busy, 1'b0);
    put(ADDR_CHAN_SEL, 8'hFF);
    get(ADDR_CHAN_SEL, v);
    chk(v, 8'h0F);
    for (int g = 0; g < 8; g++) begin
      put(ADDR_CLK_GAIN, {5'h1F, 3'(g)});
      chk(core.gain, g > 5 ? 3'h5 : g == 5 ? 3'h4 : 3'(g));
    end
    for (int i = 0; i < 24; i++) begin
      md = 2'(i);
      tm = i[2];
      lim = tm && md != SM_EXT_PIN ? 19 : 16;
      {lj, win, ch, pr, code} = 22'($urandom);
      dv = i % 3 == 0 ? 5'h00 : 5'(MIN_SAR_DIV + $urandom % 4);
      p = dv == 5'h00 ? 1 : 2 * (int'(dv) + 1);
      df = !ch[3] && pr[ch[2:1]];
      put(ADDR_CLK_GAIN, {dv, 3'h0});
      put(ADDR_PAIR_CFG, {4'h0, pr});
      put(ADDR_CHAN_SEL, {4'h0, ch});
      step(3 * p + 4);
      chk(16'(gap), 16'(p));
      chk(core.diff, df);
      u = {4'h0, ch[3] ? TEMP_SENSOR_SEL : {ch[3:1], ch[0] & !df}};
      chk(core.pos_sel, u[3:0]);
      chk(core.neg_sel, df ? {1'b0, ch[2:1], 1'b1} : 4'h0);
      if (dv == 5'h00) chk(sclk, 1'b1);
      c = {1'b1, tm, 2'b00, md, 1'b0, lj};
      put(ADDR_CONTROL, c);
      step(2);
      chk(core.track, !tm || md == SM_EXT_PIN);
      chk(core.powered, 1'b1);
      b0 = blen;
      put(ADDR_CONTROL, c | 8'h10);
      if (md != SM_BUSY_WRITE) begin
        chk(busy, 1'b0);
      end else begin
        chk(busy, 1'b1);
      end
      case (md)
        SM_TIMER3: fire = 2'h1;
        SM_TIMER2: fire = 2'h2;
        SM_EXT_PIN: pin = 1'b1;
        default: ;
      endcase
      step(1);
      fire = 2'h0;
      for (int n = 0; n < 1000 && (n < 40 || busy === 1'b1); n++) step(1);
      b0 = blen - b0;
      chk(b0 >= 15 * p + 1 && b0 <= lim * p, 1'b1);
      get(ADDR_CONTROL, v);
      chk(v, {1'b1, tm, 2'b10, md, win, lj});
      get(ADDR_RES_HIGH, v);
      get(ADDR_RES_LOW, u);
      chk({v, u}, fmt(code, lj, df));
      pin = 1'b0;
    end
    summarize();
  end
endmodule : sacu_top_bench

`default_nettype wire
